// ### logic/svfc_pkg.sv
package svfc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int REF_CLK_NS = 20;
    localparam int CONV_HALF_NS = 100;
    localparam int CONV_HALF_CYCLES = (CONV_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int SYNC_STAGES = 3;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_CAPTURE = 1'b0;
    localparam logic RST_LATCH = 1'b0;
    localparam logic [SYNC_STAGES-1:0] RST_SYNC = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SVFC_PH_LOW = 2'h1,
        SVFC_PH_HIGH = 2'h2
    } svfc_phase_t;

    typedef struct packed {
        logic reset_switch;
        logic pulse_rate_output;
    } svfc_drive_t;
endpackage

// ### logic/svfc_core.sv
`timescale 1ns/10ps
// Operation
// [RULE_01] gated comparator result is captured only at the conversion clock falling edge
// [RULE_02] latch holds while conversion clock low, follows capture flop while high
// [RULE_03] latch rising at clock rise closes the integrator reset switch
// [RULE_04] while latch is high the gating term is forced low
// [RULE_05] latch falling reopens the switch and lets comparator pass again
// [RULE_06] every reset pulse is exactly one conversion clock period long
// [RULE_07] spacing between output pulses is a whole number of clock periods
// [RULE_08] quarter-scale input gives one reset period then three integrate periods
// [RULE_09] an earlier comparator crossing shortens one integrate phase by one clock
// [RULE_10] fastest output rate is half the conversion clock
// [RULE_11] comparator stuck high settles into one pulse every two periods
// [RULE_12] outside counter counts pulses over a clock-derived gate interval
// [RULE_13] pulse output is asserted together with each reset phase
module svfc_core #(
    parameter int HALF_CYCLES = svfc_pkg::CONV_HALF_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic comparator_in,
    output logic conv_clk_out,
    output svfc_pkg::svfc_drive_t drive_out
);
    import svfc_pkg::*;

    localparam int P_CYC = 2 * HALF_CYCLES;

    // spacing counters need headroom of several periods before they saturate
    if (HALF_CYCLES < 1 || P_CYC >= (1 << CNT_W) / 4) begin : g_bad_half
        $error("svfc_core: HALF_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------
    // the first stage may be metastable, so only stages two and three are read
    logic [SYNC_STAGES-1:0] sync;
    logic cmp_level;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sync <= RST_SYNC;
        end else begin
            sync <= {sync[SYNC_STAGES-2:0], comparator_in};
        end
    end

    // a change only counts once the two later stages agree
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cmp_level <= 1'b0;
        end else if (sync[1] == sync[2]) begin
            cmp_level <= sync[2];
        end
    end

    // ------------------------------------------------------------
    // conversion clock divider
    // ------------------------------------------------------------
    // one enable per conversion edge; no second clock is made
    svfc_phase_t phase;
    logic [CNT_W-1:0] div_cnt;
    logic tick;
    logic fall_en;
    logic rise_en;

    assign tick = (div_cnt == CNT_W'(HALF_CYCLES - 1));
    assign fall_en = tick && (phase == SVFC_PH_HIGH);
    assign rise_en = tick && (phase == SVFC_PH_LOW);
    assign conv_clk_out = (phase == SVFC_PH_HIGH);

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            div_cnt <= '0;
        end else if (tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            phase <= SVFC_PH_LOW;
        end else if (tick) begin
            case (phase)
                SVFC_PH_LOW: phase <= SVFC_PH_HIGH;
                SVFC_PH_HIGH: phase <= SVFC_PH_LOW;
                default: phase <= SVFC_PH_LOW;
            endcase
        end
    end

    // ------------------------------------------------------------
    // gate, capture flop and output latch
    // ------------------------------------------------------------
    logic gate;
    logic capture;
    logic latch;

    // latch feedback blocks the comparator during reset
    assign gate = cmp_level && !latch; // see [RULE_04] see [RULE_05]

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            capture <= RST_CAPTURE;
        end else if (fall_en) begin
            capture <= gate; // see [RULE_01]
        end
    end

    // capture only moves at falls, so updating at the rise equals transparency while high
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            latch <= RST_LATCH;
            drive_out <= '0;
        end else if (rise_en) begin
            latch <= capture; // see [RULE_02] see [RULE_06] see [RULE_07]
            drive_out.reset_switch <= capture; // see [RULE_03] see [RULE_05]
            drive_out.pulse_rate_output <= capture; // see [RULE_13]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [CNT_W-1:0] pulse_len;
    logic [CNT_W-1:0] gap_len;
    logic cmp_dropped;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pulse_len <= '0;
            // saturated: no earlier pulse to measure the first spacing from
            gap_len <= '1;
            cmp_dropped <= 1'b0;
        end else begin
            pulse_len <= latch ? pulse_len + CNT_W'(1) : CNT_W'(0);
            gap_len <= (latch || gap_len == '1) ? gap_len : gap_len + CNT_W'(1);
            if ($rose(latch)) begin
                gap_len <= '0;
            end
            cmp_dropped <= latch ? 1'b0 : (cmp_dropped || !cmp_level);
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------
    // capture flop and latch
    // ------------------------------------------------------------
    // the enables stand in for the two clock edges, so they are checked first
    chk_capture_fall_only: assert property ($changed(capture) |-> $past(fall_en)) // see [RULE_01]
        else $error("capture flop moved off a falling edge");

    chk_capture_value: assert property (fall_en |=> capture == $past(gate)) // see [RULE_01]
        else $error("capture flop took the wrong value");

    chk_latch_hold: assert property ($changed(latch) |-> $past(rise_en)) // see [RULE_02]
        else $error("latch moved while clock low");

    chk_latch_follow: assert property (rise_en |=> latch == $past(capture)) // see [RULE_02]
        else $error("latch did not follow capture flop");

    chk_sync_agree: assert property ($changed(cmp_level) |-> $past(sync[1]) == $past(sync[2])) // see [RULE_01]
        else $error("comparator level moved before stages agreed");

    // ------------------------------------------------------------
    // switch, gate and pulse
    // ------------------------------------------------------------
    // gate feedback is what makes every reset exactly one period long
    chk_switch_close: assert property (rise_en && capture |=> drive_out.reset_switch) // see [RULE_03]
        else $error("reset switch not closed");

    chk_switch_open: assert property (rise_en && !capture |=> !drive_out.reset_switch) // see [RULE_05]
        else $error("reset switch not reopened");

    chk_switch_on_rise: assert property ($rose(drive_out.reset_switch) |-> conv_clk_out) // see [RULE_03]
        else $error("reset switch closed off a rising clock");

    chk_gate_blocked: assert property (latch |-> !gate) // see [RULE_04]
        else $error("gate not forced low during reset");

    chk_gate_pass: assert property (!latch |-> gate == cmp_level) // see [RULE_05]
        else $error("gate does not pass comparator");

    chk_pulse_with_reset: assert property (drive_out.pulse_rate_output == drive_out.reset_switch) // see [RULE_13]
        else $error("pulse output out of step with reset");

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    // spacing is counted in reference cycles; a saturated count skips the check
    chk_divider_range: assert property (div_cnt < CNT_W'(HALF_CYCLES)) // see [RULE_07]
        else $error("divider count out of range");

    chk_pulse_length: assert property ($fell(latch) |-> pulse_len == CNT_W'(P_CYC)) // see [RULE_06]
        else $error("reset pulse not one period");

    chk_pulse_spacing: assert property ($rose(latch) && gap_len != '1 |->
        (gap_len % CNT_W'(P_CYC)) == '0 && gap_len >= CNT_W'(P_CYC)) // see [RULE_07]
        else $error("pulse spacing not whole periods");

    chk_overrange_div2: assert property ($fell(latch) && cmp_level |->
        ##P_CYC (latch || cmp_dropped)) // see [RULE_10] see [RULE_11]
        else $error("no divide by two under overrange");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    // gap_len counts integrate cycles only, so quarter scale shows three periods
    cov_quarter: cover property ($rose(latch) && gap_len == CNT_W'(3 * P_CYC)); // see [RULE_08]
    cov_short_cycle: cover property ($rose(latch) && gap_len == CNT_W'(2 * P_CYC)); // see [RULE_09]
    cov_full_scale: cover property ($rose(latch) && gap_len == CNT_W'(P_CYC)); // see [RULE_10]
    cov_overrange: cover property ($fell(latch) && cmp_level ##P_CYC $rose(latch)); // see [RULE_11]
endmodule

// ### testbench/svfc_gate_counter.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// far side: pulse counter gated from the same clock
// ------------------------------------------------------------
module svfc_gate_counter (
    input wire logic ref_clk_in,
    input wire logic gate_in,
    input wire logic pulse_in,
    output logic [15:0] count_out
);
    logic last;
    logic gate_q;
    initial count_out = 16'h0;
    always @(posedge ref_clk_in) begin
        last <= pulse_in;
        gate_q <= gate_in;
        // new gate restarts the tally; only edges inside it count
        if (gate_in && !gate_q) begin
            count_out <= 16'h0;
        end else if (gate_in && pulse_in && !last) begin
            count_out <= count_out + 16'h1;
        end
    end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import svfc_pkg::*;
    localparam int HALF = 2;
    localparam int P = 2 * HALF;
    logic ref_clk_in = 0, rst_in = 1, comparator_in = 0, gate = 0, conv_clk;
    svfc_drive_t drive;
    logic [15:0] count;
    int n_fail = 0, check_count = 0, cyc = 0, wid = 0, gap = 0, seen = 0;
    always #10 ref_clk_in = ~ref_clk_in;
    svfc_core #(.HALF_CYCLES(HALF)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .comparator_in(comparator_in), .conv_clk_out(conv_clk), .drive_out(drive));
    svfc_gate_counter cnt (.ref_clk_in(ref_clk_in), .gate_in(gate),
        .pulse_in(drive.pulse_rate_output), .count_out(count));
    task automatic chk(string what, int exp, int got, logic ok);
        check_count++;
        if (!ok) begin
            n_fail++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // pulse shape monitor, runs through every test
    // ------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc > 3000) begin
            n_fail++;
            close_out();
        end
        if (!rst_in) begin
            chk("pair", 1, 0, drive.reset_switch === drive.pulse_rate_output);
            if (drive.pulse_rate_output === 1'b1) begin
                if (wid == 0) begin
                    chk("clock at pulse", 1, conv_clk, conv_clk === 1'b1);
                end
                if (wid == 0 && seen > 0) begin
                    chk("spacing", 2 * P, gap, gap % P == 0 && gap >= 2 * P);
                end
                wid++;
                seen++;
            end else if (wid != 0) begin
                chk("width", P, wid, wid == P);
                wid = 0;
            end
            gap = (drive.pulse_rate_output === 1'b1 && wid == 1) ? 1 : gap + 1;
        end
    end
    task automatic gated(int len, int exp, string what);
        @(posedge ref_clk_in) #1 gate = 1;
        repeat (len) @(posedge ref_clk_in);
        #1 gate = 0;
        @(posedge ref_clk_in) #1;
        chk(what, exp, count, count === 16'(exp));
        $display("test %s done", what);
    endtask
    task automatic t_idle();
        comparator_in = 0;
        gated(10 * P, 0, "idle");
    endtask
    task automatic t_single();
        @(posedge ref_clk_in) #1 comparator_in = 1;
        fork
            begin
                repeat (6) @(posedge ref_clk_in);
                #1 comparator_in = 0;
            end
            gated(10 * P, 1, "single");
        join
    endtask
    task automatic t_overrange();
        @(posedge ref_clk_in) #1 comparator_in = 1;
        repeat (10 * P) @(posedge ref_clk_in);
        gated(40 * P, 20, "overrange");
        comparator_in = 0;
        repeat (4 * P) @(posedge ref_clk_in);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_in);
        #1 rst_in = 0;
        repeat (4) @(posedge ref_clk_in);
        t_idle();
        t_single();
        t_overrange();
        t_idle();
        close_out();
    end
endmodule
